// ==== srl_cfg.svh ====
/*
  Constants for the serial register loader: word layout, select codes,
  field positions and reset values.
  Assumes it is included by bare name from the loader's files.
*/
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH

// ----------------------------------------------------------------
// word and select code
// ----------------------------------------------------------------
`define SRL_WORD_W      32
`define SRL_WORD_RST    32'h0000_0000
`define SRL_CODE_HI     3
`define SRL_CODE_LO     0
`define SRL_CODE_LAST   4'h8
`define SRL_REG_ZERO    4'h0
`define SRL_REG_ONE     4'h1
`define SRL_REG_TWO     4'h2
`define SRL_REG_THREE   4'h3
`define SRL_REG_FOUR    4'h4
`define SRL_REG_SIX     4'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SRL_INT_HI      19
`define SRL_INT_LO      4
`define SRL_PRESC_BIT   20
`define SRL_PRIMARY_NUMERATOR_HI    27
`define SRL_PRIMARY_NUMERATOR_LO    4
`define SRL_AUXILIARY_DENOMINATOR_HI     17
`define SRL_AUXILIARY_DENOMINATOR_LO     4
`define SRL_AUXILIARY_NUMERATOR_HI    17
`define SRL_AUXILIARY_NUMERATOR_LO    4
`define SRL_DBL_BIT     26
`define SRL_HALV_BIT    25
`define SRL_RCNT_HI     24
`define SRL_RCNT_LO     15
`define SRL_RSEL_BIT    14
`define SRL_CP_HI       13
`define SRL_CP_LO       10
`define SRL_MUTE_UNTIL_LOCKED_BIT    11
`define SRL_OUTEN_BIT   6
`define SRL_PWR_HI      5
`define SRL_PWR_LO      4

`endif

// ==== srl_pkg.sv ====
/*
  Types shared by the serial register loader.
  Assumes srl_cfg.svh is available on the include path.
*/
package srl_pkg;
  typedef logic [31:0] srl_word_t;
  // output power steps, lowest tail current first
  typedef enum logic [1:0] {
    SRL_PWR_M4DBM,
    SRL_PWR_M1DBM,
    SRL_PWR_P2DBM,
    SRL_PWR_P5DBM
  } srl_power_e;
endpackage : srl_pkg

// ==== srl_sync_edge.sv ====
/*
  Two-flop synchroniser with rising-edge detect, one lane per bit.
  Assumes inputs are asynchronous to clk; outputs are in the clk domain.
*/
`timescale 1ns/1ns
module srl_sync_edge
  import srl_pkg::*;
#(
  parameter int W = 4
) (
  // system
  input  wire logic         clk,
  input  wire logic         reset,
  // async inputs
  input  wire logic [W-1:0] async_in,
  // synchronised level and rising edge
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  // meta stage feeds only the second flop
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
endmodule // srl_sync_edge

// ==== srl_loader.sv ====
/*
  Serial register loader: 3-wire shift register, nine configuration
  latches, double-buffered settings and output-stage control.
  Assumes the 3-wire pins and the lock flag are asynchronous to clk and
  that the serial clock is much slower than clk.
*/
`timescale 1ns/1ns
`include "srl_cfg.svh"
module srl_loader
  import srl_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        reset,
  // 3-wire pins
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        load_strobe,
  // digital lock detector
  input  wire logic        lock_detect,
  // active feedback settings
  output logic      [15:0] integer_value_q,
  output logic             prescaler_select_q,
  output logic      [23:0] primary_numerator_q,
  output logic      [13:0] auxiliary_numerator_q,
  output logic      [13:0] auxiliary_denominator_q,
  // active reference and pump settings
  output logic             ref_doubler_q,
  output logic             reference_halver_q,
  output logic      [9:0]  ref_counter_q,
  output logic             ref_div_select_q,
  output logic      [3:0]  cp_current_q,
  // output stage
  output logic             out_enable_q,
  output srl_power_e       out_power_q,
  output logic             mute_until_locked_q,
  output logic             out_supply_on_q
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_level;
  logic [3:0] pin_rise;
  logic       sclk_rise;
  logic       le_rise;
  logic       data_s;
  logic       lock_s;

  srl_sync_edge #(.W(4)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({lock_detect, load_strobe, ser_data, ser_clk}),
    .level    (pin_level),
    .rise     (pin_rise)
  );

  // data shares the clock's sync delay, so it lines up with the edge
  assign sclk_rise = pin_rise[0];
  assign data_s    = pin_level[1];
  assign le_rise   = pin_rise[2];
  assign lock_s    = pin_level[3];

  function automatic logic code_ok(input logic [3:0] code);
    code_ok = (code <= `SRL_CODE_LAST);
  endfunction

  // ----------------------------------------------------------------
  // shift register and latches
  // ----------------------------------------------------------------
  srl_word_t  shift_q;
  srl_word_t  shift_d;
  srl_word_t  latch_q [0:8];
  srl_word_t  latch_d [0:8];
  logic [3:0] code;
  logic       load_zero;

  assign code      = shift_q[`SRL_CODE_HI:`SRL_CODE_LO];
  assign load_zero = le_rise && (code == `SRL_REG_ZERO);

  always_comb begin
    shift_d = shift_q;
    latch_d = latch_q;
    if (sclk_rise) begin
      shift_d = {shift_q[`SRL_WORD_W-2:0], data_s};
    end
    // out-of-range codes fall through untouched
    if (le_rise && code_ok(code)) begin
      latch_d[code] = shift_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shift_q <= `SRL_WORD_RST;
      for (int i = 0; i <= `SRL_CODE_LAST; i++) begin
        latch_q[i] <= `SRL_WORD_RST;
      end
    end else begin
      shift_q <= shift_d;
      latch_q <= latch_d;
    end
  end

  // ----------------------------------------------------------------
  // active copies
  // ----------------------------------------------------------------
  logic [15:0] integer_value_d;
  logic        prescaler_select_d;
  logic [23:0] primary_numerator_d;
  logic [13:0] auxiliary_numerator_d;
  logic [13:0] auxiliary_denominator_d;
  logic        ref_doubler_d;
  logic        reference_halver_d;
  logic [9:0]  ref_counter_d;
  logic        ref_div_select_d;
  logic [3:0]  cp_current_d;

  // pending values live in latches one to four until register zero lands
  always_comb begin
    integer_value_d         = integer_value_q;
    prescaler_select_d      = prescaler_select_q;
    primary_numerator_d     = primary_numerator_q;
    auxiliary_numerator_d   = auxiliary_numerator_q;
    auxiliary_denominator_d = auxiliary_denominator_q;
    ref_doubler_d           = ref_doubler_q;
    reference_halver_d      = reference_halver_q;
    ref_counter_d           = ref_counter_q;
    ref_div_select_d        = ref_div_select_q;
    cp_current_d            = cp_current_q;
    if (load_zero) begin
      integer_value_d         = shift_q[`SRL_INT_HI:`SRL_INT_LO];
      prescaler_select_d      = shift_q[`SRL_PRESC_BIT];
      primary_numerator_d     = latch_q[`SRL_REG_ONE][`SRL_PRIMARY_NUMERATOR_HI:`SRL_PRIMARY_NUMERATOR_LO];
      auxiliary_denominator_d = latch_q[`SRL_REG_TWO][`SRL_AUXILIARY_DENOMINATOR_HI:`SRL_AUXILIARY_DENOMINATOR_LO];
      auxiliary_numerator_d   = latch_q[`SRL_REG_THREE][`SRL_AUXILIARY_NUMERATOR_HI:`SRL_AUXILIARY_NUMERATOR_LO];
      ref_doubler_d           = latch_q[`SRL_REG_FOUR][`SRL_DBL_BIT];
      reference_halver_d      = latch_q[`SRL_REG_FOUR][`SRL_HALV_BIT];
      ref_counter_d           = latch_q[`SRL_REG_FOUR][`SRL_RCNT_HI:`SRL_RCNT_LO];
      ref_div_select_d        = latch_q[`SRL_REG_FOUR][`SRL_RSEL_BIT];
      cp_current_d            = latch_q[`SRL_REG_FOUR][`SRL_CP_HI:`SRL_CP_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      integer_value_q         <= '0;
      prescaler_select_q      <= 1'b0;
      primary_numerator_q     <= '0;
      auxiliary_numerator_q   <= '0;
      auxiliary_denominator_q <= '0;
      ref_doubler_q           <= 1'b0;
      reference_halver_q      <= 1'b0;
      ref_counter_q           <= '0;
      ref_div_select_q        <= 1'b0;
      cp_current_q            <= '0;
    end else begin
      integer_value_q         <= integer_value_d;
      prescaler_select_q      <= prescaler_select_d;
      primary_numerator_q     <= primary_numerator_d;
      auxiliary_numerator_q   <= auxiliary_numerator_d;
      auxiliary_denominator_q <= auxiliary_denominator_d;
      ref_doubler_q           <= ref_doubler_d;
      reference_halver_q      <= reference_halver_d;
      ref_counter_q           <= ref_counter_d;
      ref_div_select_q        <= ref_div_select_d;
      cp_current_q            <= cp_current_d;
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  logic       out_enable_d;
  srl_power_e out_power_d;
  logic       mute_until_locked_d;
  logic       out_supply_on_d;

  // register six acts at once; supply follows one cycle behind the bits
  always_comb begin
    out_enable_d        = latch_q[`SRL_REG_SIX][`SRL_OUTEN_BIT];
    out_power_d         = srl_power_e'(latch_q[`SRL_REG_SIX][`SRL_PWR_HI:`SRL_PWR_LO]);
    mute_until_locked_d = latch_q[`SRL_REG_SIX][`SRL_MUTE_UNTIL_LOCKED_BIT];
    out_supply_on_d     = out_enable_q && (!mute_until_locked_q || lock_s);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_enable_q        <= 1'b0;
      out_power_q         <= SRL_PWR_M4DBM;
      mute_until_locked_q <= 1'b0;
      out_supply_on_q     <= 1'b0;
    end else begin
      out_enable_q        <= out_enable_d;
      out_power_q         <= out_power_d;
      mute_until_locked_q <= mute_until_locked_d;
      out_supply_on_q     <= out_supply_on_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_shift_in;
    @(posedge clk) disable iff (reset)
      sclk_rise |=> shift_q == {$past(shift_q[`SRL_WORD_W-2:0]), $past(data_s)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift missed a bit");

  property p_latch_copy;
    @(posedge clk) disable iff (reset)
      (le_rise && code == `SRL_REG_SIX) |=> latch_q[`SRL_REG_SIX] == $past(shift_q);
  endproperty
  a_latch_copy: assert property (p_latch_copy) else $error("latch six not loaded");

  property p_one_latch;
    @(posedge clk) disable iff (reset)
      (le_rise && code == `SRL_REG_ONE)
        |=> latch_q[`SRL_REG_ONE] == $past(shift_q)
          && $stable(latch_q[`SRL_REG_TWO]) && $stable(latch_q[`SRL_REG_ZERO]);
  endproperty
  a_one_latch: assert property (p_one_latch) else $error("wrong latch selected");

  property p_pending_held;
    @(posedge clk) disable iff (reset)
      (le_rise && code == `SRL_REG_ONE) |=> $stable(primary_numerator_q);
  endproperty
  a_pending_held: assert property (p_pending_held) else $error("pending value applied early");

  property p_zero_applies;
    @(posedge clk) disable iff (reset)
      load_zero |=>
        primary_numerator_q == $past(latch_q[`SRL_REG_ONE][`SRL_PRIMARY_NUMERATOR_HI:`SRL_PRIMARY_NUMERATOR_LO])
        && auxiliary_denominator_q == $past(latch_q[`SRL_REG_TWO][`SRL_AUXILIARY_DENOMINATOR_HI:`SRL_AUXILIARY_DENOMINATOR_LO])
        && cp_current_q == $past(latch_q[`SRL_REG_FOUR][`SRL_CP_HI:`SRL_CP_LO]);
  endproperty
  a_zero_applies: assert property (p_zero_applies) else $error("register zero did not apply");

  property p_out_enable;
    @(posedge clk) disable iff (reset)
      (le_rise && code == `SRL_REG_SIX)
        |-> ##2 out_enable_q == $past(shift_q[`SRL_OUTEN_BIT], 2);
  endproperty
  a_out_enable: assert property (p_out_enable) else $error("output enable wrong");

  property p_out_power;
    @(posedge clk) disable iff (reset)
      (le_rise && code == `SRL_REG_SIX)
        |-> ##2 out_power_q == $past(shift_q[`SRL_PWR_HI:`SRL_PWR_LO], 2);
  endproperty
  a_out_power: assert property (p_out_power) else $error("output power wrong");

  property p_mute;
    @(posedge clk) disable iff (reset)
      (mute_until_locked_q && !lock_s) |=> !out_supply_on_q;
  endproperty
  a_mute: assert property (p_mute) else $error("supply on before lock");

  property p_bad_code;
    @(posedge clk) disable iff (reset)
      (le_rise && !code_ok(code) && !sclk_rise)
        |=> $stable(latch_q[`SRL_REG_ZERO]) && $stable(latch_q[`SRL_CODE_LAST])
          && $stable(shift_q);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("illegal code changed state");

endmodule // srl_loader

// ==== srl_host.sv ====
/*
  Host model for the loader's 3-wire port: shifts 32-bit words and
  strobes them in.
  Assumes clk is the loader's 100 MHz clock; one serial bit takes 80 ns.
*/
`timescale 1ns/1ns
module srl_host (
  // system
  input  wire logic clk,
  // 3-wire pins
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe
);
  // serial clock idles low between frames
  initial begin
    ser_clk     = 1'b0;
    ser_data    = 1'b0;
    load_strobe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // one frame
  // ----------------------------------------------------------------
  task automatic send_word(input logic [31:0] w);
    // start on an edge so every pin change lands on one
    @(posedge clk);
    for (int i = 31; i >= 0; i--) begin // msb first, code last
      ser_data <= w[i];
      tick(4);
      ser_clk <= 1'b1;
      tick(4);
      ser_clk <= 1'b0;
    end
    // no pull on the data line: released value flips
    ser_data <= ~w[0];
    tick(4);
    load_strobe <= 1'b1; // held low while shifting, one rise
    tick(4);
    load_strobe <= 1'b0;
    tick(4);
  endtask
endmodule // srl_host

// ==== srl_loader_tb_top.sv ====
/*
  Self-checking bench for the serial register loader.
  Assumes srl_cfg.svh on the include path and srl_host as the host.
*/
`timescale 1ns/1ns
`include "srl_cfg.svh"
`define SRL_CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end \
  end
module srl_loader_tb_top
  import srl_pkg::*;
;
  logic        clk;
  logic        reset;
  logic        lock_detect;
  wire         ser_clk;
  wire         ser_data;
  wire         load_strobe;
  logic [15:0] integer_value_q;
  logic        prescaler_select_q;
  logic [23:0] primary_numerator_q;
  logic [13:0] auxiliary_numerator_q;
  logic [13:0] auxiliary_denominator_q;
  logic        ref_doubler_q;
  logic        reference_halver_q;
  logic [9:0]  ref_counter_q;
  logic        ref_div_select_q;
  logic [3:0]  cp_current_q;
  logic        out_enable_q;
  srl_power_e  out_power_q;
  logic        mute_until_locked_q;
  logic        out_supply_on_q;
  int          n_mismatch;
  int          samples_checked;

  srl_loader srl_loader_i (
    .clk(clk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe), .lock_detect(lock_detect),
    .integer_value_q(integer_value_q), .prescaler_select_q(prescaler_select_q),
    .primary_numerator_q(primary_numerator_q),
    .auxiliary_numerator_q(auxiliary_numerator_q),
    .auxiliary_denominator_q(auxiliary_denominator_q),
    .ref_doubler_q(ref_doubler_q), .reference_halver_q(reference_halver_q),
    .ref_counter_q(ref_counter_q), .ref_div_select_q(ref_div_select_q),
    .cp_current_q(cp_current_q), .out_enable_q(out_enable_q),
    .out_power_q(out_power_q), .mute_until_locked_q(mute_until_locked_q),
    .out_supply_on_q(out_supply_on_q)
  );

  srl_host srl_host_i (
    .clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic results;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // frame plus strobe leaves 8 clk for latch, stage and supply to settle
  task automatic wr(input logic [31:0] w);
    srl_host_i.send_word(w);
    #1;
  endtask

  task automatic set_lock(input logic v);
    @(posedge clk);
    lock_detect <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic chk_act(input logic [31:0] a0, a1, a2, a3, a4);
    `SRL_CHK("int", a0[19:4], integer_value_q)
    `SRL_CHK("presc", a0[20], prescaler_select_q)
    `SRL_CHK("num1", a1[27:4], primary_numerator_q)
    `SRL_CHK("den2", a2[17:4], auxiliary_denominator_q)
    `SRL_CHK("num2", a3[17:4], auxiliary_numerator_q)
    `SRL_CHK("dbl", a4[26], ref_doubler_q)
    `SRL_CHK("halv", a4[25], reference_halver_q)
    `SRL_CHK("rcnt", a4[24:15], ref_counter_q)
    `SRL_CHK("rsel", a4[14], ref_div_select_q)
    `SRL_CHK("cp", a4[13:10], cp_current_q)
  endtask

  task automatic chk_out(input logic en, input logic [1:0] pw, input logic mt, sup);
    `SRL_CHK("en", en, out_enable_q)
    `SRL_CHK("pwr", pw, out_power_q)
    `SRL_CHK("mute", mt, mute_until_locked_q)
    `SRL_CHK("supply", sup, out_supply_on_q)
  endtask

  // a hang counts as a failure
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    reset       = 1'b1;
    lock_detect = 1'b0;
    n_mismatch      = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk_act('0, '0, '0, '0, '0);
    chk_out(1'b0, 2'h0, 1'b0, 1'b0);
    wr(32'h0ABC_DEF1);
    wr(32'h0002_3452);
    wr(32'h0001_2343);
    // halver low, doubler and divider select high: catches swapped or stuck bits
    wr(32'h04AA_E804);
    chk_act('0, '0, '0, '0, '0);
    wr(32'h0013_5790);
    chk_act(32'h0013_5790, 32'h0ABC_DEF1, 32'h0002_3452, 32'h0001_2343,
            32'h04AA_E804);
    // denominator change waits for the next register zero load
    wr(32'h0000_0012);
    chk_act(32'h0013_5790, 32'h0ABC_DEF1, 32'h0002_3452, 32'h0001_2343,
            32'h04AA_E804);
    wr(32'h0000_0170);
    chk_act(32'h0000_0170, 32'h0ABC_DEF1, 32'h0000_0012, 32'h0001_2343,
            32'h04AA_E804);
    for (int p = 0; p < 4; p++) begin
      wr(32'h0000_0046 | (p << 4));
      chk_out(1'b1, p[1:0], 1'b0, 1'b1);
    end
    wr(32'h0000_0846);
    chk_out(1'b1, 2'h0, 1'b1, 1'b0);
    set_lock(1'b1);
    `SRL_CHK("supply", 1'b1, out_supply_on_q)
    set_lock(1'b0);
    `SRL_CHK("supply", 1'b0, out_supply_on_q)
    wr(32'h0000_0006);
    chk_out(1'b0, 2'h0, 1'b0, 1'b0);
    // unused and undefined codes with every data bit set
    for (int c = 5; c < 16; c++) begin
      if (c != 6) begin
        wr(32'hFFFF_FFF0 | c);
      end
    end
    chk_out(1'b0, 2'h0, 1'b0, 1'b0);
    wr(32'h0000_0170);
    chk_act(32'h0000_0170, 32'h0ABC_DEF1, 32'h0000_0012, 32'h0001_2343,
            32'h04AA_E804);
    results();
  end
endmodule // srl_loader_tb_top
